// *** rtl/tsac_consts.svh ***
// constants for the type-c source attach controller
//
// Contract
// - watch both cc pins for terminations
// - single rd: vbus on, sink flag low
// - polarity released for cc1, low for cc2
// - rd plus ra: vconn on ra pin
// - lone ra: power off, flags released
// - ra on both: audio flag, power off
// - rd on both: debug flag, power off
// - both open: nothing on, flags released
// - status outputs are open drain
// - straps select std, 1.5 a, 3 a
// - 3.4 a limit, load detect only both high
// - overtemp in current limit turns switch off
// - restart after cooling, keep cycling
// - undervoltage holds switch disabled
// - heavy load flag in 3 a mode
// - audio detach watched on cc2 only
// - debug detach watched on cc1 only
// - discharge after sink removal, 65 ms
`ifndef TSAC_CONSTS_SVH
`define TSAC_CONSTS_SVH

// -----------------------------------------------------------------
// termination and advertisement codes
// -----------------------------------------------------------------
`define TSAC_CC_OPEN 2'h0
`define TSAC_CC_RD 2'h1
`define TSAC_CC_RA 2'h2
`define TSAC_ADV_STD 2'h0
`define TSAC_ADV_1P5 2'h1
`define TSAC_ADV_3P0 2'h2

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define TSAC_OFS_CTRL 8'h00
`define TSAC_OFS_STATUS 8'h04
`define TSAC_CTRL_EN_BIT 0
`define TSAC_CTRL_VCONN_BIT 1
`define TSAC_CTRL_RST 2'h3
`define TSAC_STS_CC1_LSB 0
`define TSAC_STS_CC2_LSB 2
`define TSAC_STS_STATE_LSB 4
`define TSAC_STS_THERM_BIT 6
`define TSAC_STS_UVLO_BIT 7
`define TSAC_STS_HEAVY_BIT 8
`define TSAC_STS_DCHG_BIT 9
`define TSAC_STS_ADV_LSB 10

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define TSAC_MCLK_KHZ 20000
`define TSAC_DCHG_TIME_US 65000

`endif

// *** rtl/tsac_pkg.sv ***
// types for the type-c source attach controller
`include "tsac_consts.svh"
package tsac_pkg;
    typedef logic [1:0] tsac_cc_t;
    typedef logic [1:0] tsac_adv_t;
    typedef enum logic [1:0] {TSAC_ST_IDLE, TSAC_ST_SINK, TSAC_ST_AUDIO, TSAC_ST_DEBUG} tsac_att_st_t;
    typedef enum logic {TSAC_TH_RUN, TSAC_TH_OFF} tsac_th_st_t;
    typedef enum logic [1:0] {TSAC_K_NONE, TSAC_K_SINK, TSAC_K_AUDIO, TSAC_K_DEBUG} tsac_kind_t;
endpackage

// *** rtl/tsac_sync_if.sv ***
// synchronised pin levels passed from the synchroniser to the controller
`timescale 1ns/100ps
`default_nettype none
interface tsac_sync_if;
    logic [1:0] cc1;
    logic [1:0] cc2;
    logic       adv;
    logic       adv_hi;
    logic       over_temp;
    logic       cooled;
    logic       uvlo;
    logic       ilim;
    logic       load_over;
    modport prod (output cc1, cc2, adv, adv_hi, over_temp, cooled, uvlo, ilim, load_over);
    modport cons (input cc1, cc2, adv, adv_hi, over_temp, cooled, uvlo, ilim, load_over);
endinterface
`default_nettype wire

// *** rtl/tsac_pin_sync.sv ***
// two-stage synchroniser for all asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module tsac_pin_sync
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // raw pins
    input  wire logic [1:0] cc1_class_i,
    input  wire logic [1:0] cc2_class_i,
    input  wire logic       advert_select_i,
    input  wire logic       advert_high_select_i,
    input  wire logic       over_temp_i,
    input  wire logic       temp_cooled_i,
    input  wire logic       uvlo_i,
    input  wire logic       ilim_active_i,
    input  wire logic       load_over_i,
    // synchronised levels
    tsac_sync_if.prod       sy
);
    logic [10:0] s1_q;
    logic [10:0] s2_q;

    // -----------------------------------------------------------------
    // double flop, first stage feeds only the second
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
        end
        else if (ce_i)
        begin
            s1_q <= {cc1_class_i, cc2_class_i, advert_select_i, advert_high_select_i,
                     over_temp_i, temp_cooled_i, uvlo_i, ilim_active_i, load_over_i};
            s2_q <= s1_q;
        end
    end

    assign sy.cc1       = s2_q[10:9];
    assign sy.cc2       = s2_q[8:7];
    assign sy.adv       = s2_q[6];
    assign sy.adv_hi    = s2_q[5];
    assign sy.over_temp = s2_q[4];
    assign sy.cooled    = s2_q[3];
    assign sy.uvlo      = s2_q[2];
    assign sy.ilim      = s2_q[1];
    assign sy.load_over = s2_q[0];
endmodule
`default_nettype wire

// *** rtl/tsac_top.sv ***
// type-c source attach controller: attach decision, power gating, apb registers
`timescale 1ns/100ps
`default_nettype none
module tsac_top
    import tsac_pkg::*;
#(
    parameter int DCHG_CYCLES = `TSAC_DCHG_TIME_US * `TSAC_MCLK_KHZ / 1000
)
(
    // clock, reset, enable
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // termination classifiers and analog indications
    input  wire logic [1:0]  cc1_class_i,
    input  wire logic [1:0]  cc2_class_i,
    input  wire logic        advert_select_i,
    input  wire logic        advert_high_select_i,
    input  wire logic        over_temp_i,
    input  wire logic        temp_cooled_i,
    input  wire logic        uvlo_i,
    input  wire logic        ilim_active_i,
    input  wire logic        load_over_i,
    // power switches
    output logic             vbus_switch_on_o,
    output logic             vconn_cc1_on_o,
    output logic             vconn_cc2_on_o,
    output logic             discharge_on_o,
    output logic      [1:0]  advert_level_o,
    output logic             ilim_high_o,
    output logic             load_detect_en_o,
    // open-drain status pins
    output logic             polarity_flag_n_o,
    output logic             polarity_flag_n_oe_o,
    output logic             sink_attached_n_o,
    output logic             sink_attached_n_oe_o,
    output logic             audio_acc_n_o,
    output logic             audio_acc_n_oe_o,
    output logic             debug_acc_n_o,
    output logic             debug_acc_n_oe_o,
    output logic             heavy_load_flag_n_o,
    output logic             heavy_load_flag_n_oe_o
);
    tsac_sync_if  cs ();
    tsac_att_st_t state_q;
    tsac_th_st_t  th_q;
    tsac_kind_t   kind;
    logic [1:0]   ctrl_q;
    logic         was_sink_q;
    logic [20:0]  dchg_cnt_q;
    logic         sts_heavy_q;
    logic [31:0]  sts;
    logic         port_en;

    tsac_pin_sync u_sync
    (
        .mclk_i               (mclk_i),
        .rst_n_i              (rst_n_i),
        .ce_i                 (ce_i),
        .cc1_class_i          (cc1_class_i),
        .cc2_class_i          (cc2_class_i),
        .advert_select_i      (advert_select_i),
        .advert_high_select_i (advert_high_select_i),
        .over_temp_i          (over_temp_i),
        .temp_cooled_i        (temp_cooled_i),
        .uvlo_i               (uvlo_i),
        .ilim_active_i        (ilim_active_i),
        .load_over_i          (load_over_i),
        .sy                   (cs)
    );

    // -----------------------------------------------------------------
    // decoding
    // -----------------------------------------------------------------
    function automatic tsac_kind_t cc_kind(input tsac_cc_t a, input tsac_cc_t b);
        tsac_kind_t k;
        k = TSAC_K_NONE;
        if (a == `TSAC_CC_RD && (b == `TSAC_CC_OPEN || b == `TSAC_CC_RA))
            k = TSAC_K_SINK;
        else if (b == `TSAC_CC_RD && (a == `TSAC_CC_OPEN || a == `TSAC_CC_RA))
            k = TSAC_K_SINK;
        else if (a == `TSAC_CC_RA && b == `TSAC_CC_RA)
            k = TSAC_K_AUDIO;
        else if (a == `TSAC_CC_RD && b == `TSAC_CC_RD)
            k = TSAC_K_DEBUG;
        return k;
    endfunction

    function automatic tsac_adv_t adv_level(input logic sel, input logic hi);
        tsac_adv_t l;
        l = `TSAC_ADV_STD;
        if (sel && hi)
            l = `TSAC_ADV_3P0;
        else if (sel)
            l = `TSAC_ADV_1P5;
        return l;
    endfunction

    assign kind    = cc_kind(cs.cc1, cs.cc2);
    assign port_en = ctrl_q[`TSAC_CTRL_EN_BIT];

    // -----------------------------------------------------------------
    // attach state machine
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_q <= TSAC_ST_IDLE;
        else if (ce_i)
        begin
            case (state_q)
                TSAC_ST_IDLE:
                begin
                    if (port_en && kind == TSAC_K_SINK)
                        state_q <= TSAC_ST_SINK;
                    else if (port_en && kind == TSAC_K_AUDIO)
                        state_q <= TSAC_ST_AUDIO;
                    else if (port_en && kind == TSAC_K_DEBUG)
                        state_q <= TSAC_ST_DEBUG;
                end
                TSAC_ST_SINK:
                begin
                    if (!port_en || kind != TSAC_K_SINK)
                        state_q <= TSAC_ST_IDLE;
                end
                // accessories leave only on their own pin, so a wiggle on the other is ignored
                TSAC_ST_AUDIO:
                begin
                    if (!port_en || cs.cc2 != `TSAC_CC_RA)
                        state_q <= TSAC_ST_IDLE;
                end
                TSAC_ST_DEBUG:
                begin
                    if (!port_en || cs.cc1 != `TSAC_CC_RD)
                        state_q <= TSAC_ST_IDLE;
                end
                default:
                    state_q <= TSAC_ST_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // thermal cycling
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            th_q <= TSAC_TH_RUN;
        else if (ce_i)
        begin
            case (th_q)
                TSAC_TH_RUN:
                begin
                    if (cs.ilim && cs.over_temp)
                        th_q <= TSAC_TH_OFF;
                end
                TSAC_TH_OFF:
                begin
                    if (cs.cooled)
                        th_q <= TSAC_TH_RUN;
                end
                default:
                    th_q <= TSAC_TH_RUN;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // power switches and straps
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            vbus_switch_on_o <= 1'b0;
            vconn_cc1_on_o   <= 1'b0;
            vconn_cc2_on_o   <= 1'b0;
            advert_level_o   <= `TSAC_ADV_STD;
            ilim_high_o      <= 1'b0;
            load_detect_en_o <= 1'b0;
        end
        else if (ce_i)
        begin
            vbus_switch_on_o <= state_q == TSAC_ST_SINK && th_q == TSAC_TH_RUN && !cs.uvlo;
            vconn_cc1_on_o   <= state_q == TSAC_ST_SINK && cs.cc1 == `TSAC_CC_RA
                                && ctrl_q[`TSAC_CTRL_VCONN_BIT];
            vconn_cc2_on_o   <= state_q == TSAC_ST_SINK && cs.cc2 == `TSAC_CC_RA
                                && ctrl_q[`TSAC_CTRL_VCONN_BIT];
            advert_level_o   <= adv_level(cs.adv, cs.adv_hi);
            ilim_high_o      <= cs.adv && cs.adv_hi;
            load_detect_en_o <= cs.adv && cs.adv_hi;
        end
    end

    // -----------------------------------------------------------------
    // open-drain status pins: data held low, enable means pulled low
    // -----------------------------------------------------------------
    assign polarity_flag_n_o   = 1'b0;
    assign sink_attached_n_o   = 1'b0;
    assign audio_acc_n_o       = 1'b0;
    assign debug_acc_n_o       = 1'b0;
    assign heavy_load_flag_n_o = 1'b0;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            polarity_flag_n_oe_o   <= 1'b0;
            sink_attached_n_oe_o   <= 1'b0;
            audio_acc_n_oe_o       <= 1'b0;
            debug_acc_n_oe_o       <= 1'b0;
            heavy_load_flag_n_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            polarity_flag_n_oe_o   <= state_q == TSAC_ST_SINK && cs.cc2 == `TSAC_CC_RD;
            sink_attached_n_oe_o   <= state_q == TSAC_ST_SINK;
            audio_acc_n_oe_o       <= state_q == TSAC_ST_AUDIO;
            debug_acc_n_oe_o       <= state_q == TSAC_ST_DEBUG;
            heavy_load_flag_n_oe_o <= state_q == TSAC_ST_SINK && cs.adv && cs.adv_hi && cs.load_over;
        end
    end

    // -----------------------------------------------------------------
    // output discharge after sink removal
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            was_sink_q     <= 1'b0;
            dchg_cnt_q     <= 21'h000000;
            discharge_on_o <= 1'b0;
        end
        else if (ce_i)
        begin
            was_sink_q <= state_q == TSAC_ST_SINK;
            if (was_sink_q && state_q != TSAC_ST_SINK)
                dchg_cnt_q <= 21'(DCHG_CYCLES);
            else if (state_q == TSAC_ST_SINK)
                dchg_cnt_q <= 21'h000000;
            else if (dchg_cnt_q != 21'h000000)
                dchg_cnt_q <= dchg_cnt_q - 21'h000001;
            discharge_on_o <= (was_sink_q && state_q != TSAC_ST_SINK) || dchg_cnt_q > 21'h000001;
        end
    end

    // -----------------------------------------------------------------
    // apb slave, no wait state; pready rises with penable and every answer leaves a flop
    // -----------------------------------------------------------------
    always_comb
    begin
        sts = 32'h00000000;
        sts[`TSAC_STS_CC1_LSB +: 2]   = cs.cc1;
        sts[`TSAC_STS_CC2_LSB +: 2]   = cs.cc2;
        sts[`TSAC_STS_STATE_LSB +: 2] = state_q;
        sts[`TSAC_STS_THERM_BIT]      = th_q == TSAC_TH_OFF;
        sts[`TSAC_STS_UVLO_BIT]       = cs.uvlo;
        sts[`TSAC_STS_HEAVY_BIT]      = heavy_load_flag_n_oe_o;
        sts[`TSAC_STS_DCHG_BIT]       = discharge_on_o;
        sts[`TSAC_STS_ADV_LSB +: 2]   = advert_level_o;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
        else if (ce_i)
        begin
            pready_o <= psel_i && !penable_i;
            if (psel_i && !penable_i)
            begin
                pslverr_o <= paddr_i != `TSAC_OFS_CTRL && paddr_i != `TSAC_OFS_STATUS;
                if (paddr_i == `TSAC_OFS_CTRL)
                    prdata_o <= {30'h00000000, ctrl_q};
                else if (paddr_i == `TSAC_OFS_STATUS)
                    prdata_o <= sts;
                else
                    prdata_o <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ctrl_q <= `TSAC_CTRL_RST;
        else if (ce_i && psel_i && penable_i && pready_o && pwrite_i && paddr_i == `TSAC_OFS_CTRL)
            ctrl_q <= pwdata_i[1:0];
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i || !ce_i);

    a_vbus_sink_only: assert property (vbus_switch_on_o |-> sink_attached_n_oe_o)
        else $error("vbus on without sink flag");
    a_sink_vbus_on: assert property ((state_q == TSAC_ST_SINK && th_q == TSAC_TH_RUN && !cs.uvlo) |=> vbus_switch_on_o)
        else $error("sink seen but vbus off");
    a_pol_needs_cc2: assert property (polarity_flag_n_oe_o |-> $past(cs.cc2) == `TSAC_CC_RD && sink_attached_n_oe_o)
        else $error("polarity low without rd on cc2");
    a_vconn_on_ra: assert property ((vconn_cc1_on_o |-> $past(cs.cc1) == `TSAC_CC_RA) and !(vconn_cc1_on_o && vconn_cc2_on_o))
        else $error("vconn on wrong pin");
    a_idle_all_off: assert property (state_q == TSAC_ST_IDLE |=> !vbus_switch_on_o && !vconn_cc1_on_o && !vconn_cc2_on_o && !sink_attached_n_oe_o)
        else $error("power on while idle");
    a_audio_power_off: assert property (audio_acc_n_oe_o |-> !vbus_switch_on_o && !vconn_cc1_on_o && !vconn_cc2_on_o)
        else $error("power on with audio accessory");
    a_debug_flags_clear: assert property (debug_acc_n_oe_o |-> !vbus_switch_on_o && !polarity_flag_n_oe_o && !sink_attached_n_oe_o)
        else $error("debug accessory with power or flags");
    a_limit_follows_adv: assert property (ilim_high_o == (advert_level_o == `TSAC_ADV_3P0) && load_detect_en_o == ilim_high_o)
        else $error("current limit does not match advertisement");
    a_therm_cut_off: assert property ((th_q == TSAC_TH_RUN && cs.ilim && cs.over_temp) |=> ##1 !vbus_switch_on_o)
        else $error("switch still on after thermal trip");
    a_uvlo_holds_off: assert property (cs.uvlo |=> !vbus_switch_on_o)
        else $error("switch on under undervoltage");
    a_audio_detach_cc2: assert property ((state_q == TSAC_ST_AUDIO && cs.cc2 != `TSAC_CC_RA) |=> state_q == TSAC_ST_IDLE ##1 !audio_acc_n_oe_o)
        else $error("audio flag kept after cc2 detach");
    a_debug_detach_cc1: assert property ((state_q == TSAC_ST_DEBUG && cs.cc1 == `TSAC_CC_RD && port_en) |=> state_q == TSAC_ST_DEBUG)
        else $error("debug left while cc1 still rd");
    a_dchg_after_sink: assert property (($past(state_q) == TSAC_ST_SINK && state_q != TSAC_ST_SINK) |=> discharge_on_o)
        else $error("no discharge after sink removal");

    c_sink_attach: cover property (state_q == TSAC_ST_IDLE ##1 state_q == TSAC_ST_SINK ##1 vbus_switch_on_o);
    c_audio_attach: cover property (audio_acc_n_oe_o);
    c_debug_attach: cover property (debug_acc_n_oe_o);
    c_thermal_cycle: cover property (th_q == TSAC_TH_OFF ##1 th_q == TSAC_TH_RUN);
endmodule
`default_nettype wire

// *** tb/tsac_sink_model.sv ***
// far-side model: sink, cable or accessory terminations on the cc pins
`timescale 1ns/100ps
`default_nettype none
`include "tsac_consts.svh"
module tsac_sink_model
    import tsac_pkg::*;
(
    // clock
    input  wire logic mclk_i,
    // terminations seen at the receptacle
    output var tsac_cc_t cc1_class_o,
    output var tsac_cc_t cc2_class_o
);
    initial
    begin
        cc1_class_o = `TSAC_CC_OPEN;
        cc2_class_o = `TSAC_CC_OPEN;
    end
    // a sink shows rd on both plug contacts; the cable routes one of them to the port
    // both pins change on one edge, like a real plug, so no half-plugged mix is seen
    task automatic plug(input tsac_cc_t a, input tsac_cc_t b);
        @(posedge mclk_i);
        cc1_class_o <= a;
        cc2_class_o <= b;
    endtask
endmodule
`default_nettype wire

// *** tb/typec_source_attach_control_tb.sv ***
// self-checking bench for the type-c source attach controller
`timescale 1ns/100ps
`default_nettype none
`include "tsac_consts.svh"
module typec_source_attach_control_tb
    import tsac_pkg::*;
;
    // ----
    // signals
    // ----
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  pad = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic        prdy, perr, err;
    tsac_cc_t    cc1, cc2;
    logic        adv = 1'b0, advh = 1'b0, otmp = 1'b0, cool = 1'b0, uvlo = 1'b0, ilim = 1'b0, lov = 1'b0;
    logic        vbus, vc1, vc2, dchg, ilh, lde;
    tsac_adv_t   alv;
    logic [4:0]  odn, oe, pin;
    logic [11:0] tbl [10] = '{12'h00f, 12'h44b, 12'h143, 12'h20f, 12'h80f,
                              12'h65b, 12'h963, 12'h50e, 12'ha0d, 12'hf0f};
    logic [7:0]  sx [4] = '{8'h00, 8'h00, 8'h08, 8'h16};
    int          n_mismatch = 0;
    int          comparisons = 0;
    // pull-ups on the open-drain pins
    assign pin = odn | ~oe;
    always #25 mclk_i = ~mclk_i;
    tsac_sink_model sink (.mclk_i(mclk_i), .cc1_class_o(cc1), .cc2_class_o(cc2));
    tsac_top #(.DCHG_CYCLES(20)) uut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .cc1_class_i(cc1), .cc2_class_i(cc2), .advert_select_i(adv), .advert_high_select_i(advh),
        .over_temp_i(otmp), .temp_cooled_i(cool), .uvlo_i(uvlo), .ilim_active_i(ilim), .load_over_i(lov),
        .vbus_switch_on_o(vbus), .vconn_cc1_on_o(vc1), .vconn_cc2_on_o(vc2), .discharge_on_o(dchg),
        .advert_level_o(alv), .ilim_high_o(ilh), .load_detect_en_o(lde),
        .polarity_flag_n_o(odn[4]), .polarity_flag_n_oe_o(oe[4]),
        .sink_attached_n_o(odn[3]), .sink_attached_n_oe_o(oe[3]),
        .audio_acc_n_o(odn[2]), .audio_acc_n_oe_o(oe[2]),
        .debug_acc_n_o(odn[1]), .debug_acc_n_oe_o(oe[1]),
        .heavy_load_flag_n_o(odn[0]), .heavy_load_flag_n_oe_o(oe[0]));
    // ----
    // tasks
    // ----
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // request held until pready is seen high at a rising edge; data taken at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge mclk_i);
        pen <= 1'b1;
        k = 0;
        @(posedge mclk_i);
        while (prdy !== 1'b1 && k < 20)
        begin
            @(posedge mclk_i);
            k++;
        end
        if (k == 20)
        begin
            chk_word(32'h0, 32'h1, "apb timeout");
            close_out();
        end
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    function automatic logic [7:0] att();
        return {1'b0, vbus, vc1, vc2, pin[4:1]};
    endfunction
    task automatic step(input tsac_cc_t a, input tsac_cc_t b, input logic [7:0] e);
        sink.plug(a, b);
        settle(6);
        chk_bits(att(), e, "attach");
    endtask
    // ----
    // sequence
    // ----
    initial
    begin
        settle(3);
        chk_word({23'h0, vbus, vc1, vc2, dchg, oe}, 32'h0, "reset outputs");
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, `TSAC_OFS_CTRL, 32'h0);
        chk_word(rd, 32'h3, "ctrl reset");
        for (int i = 0; i < 10; i++)
        begin
            step(`TSAC_CC_OPEN, `TSAC_CC_OPEN, 8'h0f);
            step(tbl[i][11:10], tbl[i][9:8], tbl[i][7:0]);
        end
        for (int s = 0; s < 4; s++)
        begin
            @(posedge mclk_i);
            adv <= s[1];
            advh <= s[0];
            settle(4);
            chk_bits({3'h0, alv, ilh, lde, 1'b0}, sx[s], "straps");
        end
        step(`TSAC_CC_RD, `TSAC_CC_OPEN, 8'h4b);
        apb(1'b0, `TSAC_OFS_STATUS, 32'h0);
        chk_word(rd & 32'h3f, 32'h11, "status");
        @(posedge mclk_i);
        lov <= 1'b1;
        settle(4);
        chk_bits({7'h0, pin[0]}, 8'h00, "heavy on");
        @(posedge mclk_i);
        advh <= 1'b0;
        settle(4);
        chk_bits({7'h0, pin[0]}, 8'h01, "heavy off");
        @(posedge mclk_i);
        ilim <= 1'b1;
        otmp <= 1'b1;
        settle(6);
        chk_bits(att(), 8'h0b, "thermal off");
        for (int c = 0; c < 2; c++)
        begin
            @(posedge mclk_i);
            otmp <= 1'b0;
            cool <= 1'b1;
            settle(6);
            chk_bits(att(), 8'h4b, "restart");
            @(posedge mclk_i);
            cool <= 1'b0;
            otmp <= c == 0;
            settle(6);
            chk_bits(att(), c == 0 ? 8'h0b : 8'h4b, "cycling");
        end
        @(posedge mclk_i);
        ilim <= 1'b0;
        uvlo <= 1'b1;
        settle(6);
        chk_bits(att(), 8'h0b, "uvlo");
        @(posedge mclk_i);
        uvlo <= 1'b0;
        settle(6);
        chk_bits(att(), 8'h4b, "uvlo clear");
        apb(1'b0, 8'h10, 32'h0);
        chk_word({err, rd[30:0]}, 32'h80000000, "unmapped");
        apb(1'b1, `TSAC_OFS_CTRL, 32'h0);
        settle(4);
        chk_bits(att(), 8'h0f, "port disabled");
        apb(1'b1, `TSAC_OFS_CTRL, 32'h3);
        settle(6);
        chk_bits(att(), 8'h4b, "port enabled");
        step(`TSAC_CC_OPEN, `TSAC_CC_OPEN, 8'h0f);
        chk_bits({7'h0, dchg}, 8'h01, "discharge on");
        settle(25);
        chk_bits({7'h0, dchg}, 8'h00, "discharge off");
        step(`TSAC_CC_RA, `TSAC_CC_RA, 8'h0d);
        step(`TSAC_CC_RD, `TSAC_CC_RA, 8'h0d);
        step(`TSAC_CC_RA, `TSAC_CC_OPEN, 8'h0f);
        step(`TSAC_CC_RD, `TSAC_CC_RD, 8'h0e);
        step(`TSAC_CC_RD, `TSAC_CC_RA, 8'h0e);
        step(`TSAC_CC_OPEN, `TSAC_CC_RA, 8'h0f);
        close_out();
    end
endmodule
`default_nettype wire
